// ==== common/alu_exec_cfg.svh ====
// Purpose: constants for the byte subtract/swap/rotate execution datapath
// Assumes: included by its bare name; register offsets are byte addresses on apb
// Notes: holds offsets, field positions, reset values and phase count
// Overview of operation
// - Each instruction runs over four clock cycles, one per phase: decode, read, process, write.
// - The block takes a 7-bit file address (0..127) and a destination bit of zero or one.
// - Subtraction computes file minus accumulator by two's-complement addition and updates carry, digit carry, zero.
// - After subtraction carry is cleared on a borrow (negative result) and set when zero or positive.
// - Destination zero writes the accumulator, destination one writes back to the addressed file register; direction load writes dirReg for either destination.
// - Rotate left moves bits toward the top through carry: old carry to bit 0, old bit 7 to carry.
// - Rotate right moves bits toward bit 0 through carry: old carry to bit 7, old bit 0 to carry.
`ifndef ALU_EXEC_CFG_SVH
`define ALU_EXEC_CFG_SVH
`define OFF_CTRL     12'h000
`define OFF_ACC      12'h004
`define OFF_STATUS   12'h008
`define OFF_RESULT   12'h00c
`define OFF_DIRREG   12'h010
`define OFF_FILE     12'h200
`define CTRL_ADDR_LSB 0
`define CTRL_DEST_BIT 7
`define CTRL_OP_LSB   8
`define CTRL_GO_BIT   31
`define STAT_C_BIT    0
`define STAT_DIGIT_BIT 1
`define STAT_Z_BIT    2
`define STAT_BUSY_BIT 3
`define RST_ACC      8'h00
`define RST_FLAGS    3'h0
`define RST_DIRREG   8'hff
`define PHASE_COUNT  4
`endif

// ==== common/alu_exec_pkg.sv ====
// Purpose: types for the execution datapath
// Assumes: constants live in alu_exec_cfg.svh
// Notes: none
package alu_exec_pkg;
    typedef enum logic [2:0] {
        OP_SUB  = 3'h0,
        OP_SWAP = 3'h1,
        OP_RLC  = 3'h2,
        OP_RRC  = 3'h3,
        OP_DIR  = 3'h4
    } op_e;
    typedef enum logic [3:0] {
        PH_DECODE  = 4'h1,
        PH_READ    = 4'h2,
        PH_PROCESS = 4'h4,
        PH_WRITE   = 4'h8
    } phase_e;
    typedef struct packed {
        logic       zero;
        logic       digitCarry;
        logic       carry;
    } flags_s;
    typedef struct packed {
        op_e        op;
        logic       dest;
        logic [6:0] addr;
    } instr_s;
endpackage

// ==== core/file_ram.sv ====
// Purpose: 128 x 8 file register memory with registered read data
// Assumes: single clock, one write port, one read port
// Notes: read data appear on the same edge that samples the read address
`timescale 1ns/1ps
module file_ram
(
    input  wire logic       clock,    // core clock
    input  wire logic       wrEn,     // write strobe
    input  wire logic [6:0] wrAddr,   // write address
    input  wire logic [7:0] wrData,   // write data
    input  wire logic [6:0] rdAddr,   // read address
    output logic      [7:0] rdData    // registered read data
);
    logic [7:0] mem [0:127];

    always_ff @(posedge clock)
    begin
        if (wrEn)
        begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule

// ==== core/byte_subtract_swap_rotate_exec.sv ====
// Purpose: executes subtract, nibble exchange, rotates through carry and direction load
// Assumes: apb slave, 32-bit data, one instruction at a time
// Notes: each instruction walks decode, read, process and write phases
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "alu_exec_cfg.svh"
module byte_subtract_swap_rotate_exec
(
    input  wire logic        clock,      // 100 MHz core clock
    input  wire logic        rst_n,      // async reset, active low
    input  wire logic        psel,       // apb select
    input  wire logic        penable,    // apb access phase
    input  wire logic        pwrite,     // apb direction
    input  wire logic [11:0] paddr,      // apb byte address
    input  wire logic [31:0] pwdata,     // apb write data
    output logic             pready,     // apb ready
    output logic      [31:0] prdata,     // apb read data
    output logic             pslverr,    // apb error
    output alu_exec_pkg::flags_s flags,  // status flags
    output logic             busy        // instruction in flight
);
    import alu_exec_pkg::*;

    logic          [7:0] acc;
    logic          [7:0] result;
    logic          [7:0] dirReg;
    instr_s              instr;
    phase_e              phase;
    phase_e              next_phase;
    logic          [7:0] operand;
    logic          [7:0] ramRd;
    logic          [7:0] next_result;
    flags_s              next_flags;
    logic                fileWr;

    wire logic accessPhase = psel & penable;
    wire logic wrAccess    = accessPhase & pwrite;
    wire logic rdAccess    = accessPhase & ~pwrite;
    wire logic hitCtrl     = paddr == `OFF_CTRL;
    wire logic hitAcc      = paddr == `OFF_ACC;
    wire logic hitStatus   = paddr == `OFF_STATUS;
    wire logic hitResult   = paddr == `OFF_RESULT;
    wire logic hitDir      = paddr == `OFF_DIRREG;
    // write-only window that preloads the file memory, one byte per word, reads as zero
    wire logic hitFile     = {paddr[11:9], 9'h000} == `OFF_FILE;
    wire logic mapped      = hitCtrl | hitAcc | hitStatus | hitResult | hitDir | hitFile;
    wire logic startCmd    = wrAccess & hitCtrl & pwdata[`CTRL_GO_BIT] & ~busy;
    wire logic accWrSw     = wrAccess & hitAcc & ~busy;
    wire logic fileWrSw    = wrAccess & hitFile & ~busy;

    // two's-complement subtraction: f + ~w + 1, carry out means no borrow
    function automatic logic [8:0] addc(input logic [7:0] a, input logic [7:0] b, input logic cin);
        addc = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    endfunction

    wire logic [8:0] subFull = addc(operand, ~acc, 1'b1);
    wire logic [4:0] subLow  = 5'(addc({4'h0, operand[3:0]}, {4'h0, ~acc[3:0]}, 1'b1));

    always_comb
    begin
        next_result = operand;
        next_flags  = flags;
        case (instr.op)
            OP_SUB:
            begin
                next_result           = subFull[7:0];
                next_flags.carry      = subFull[8];
                next_flags.digitCarry = subLow[4];
                next_flags.zero       = subFull[7:0] == 8'h00;
            end
            OP_SWAP:
            begin
                next_result = {operand[3:0], operand[7:4]};
            end
            OP_RLC:
            begin
                next_result      = {operand[6:0], flags.carry};
                next_flags.carry = operand[7];
            end
            OP_RRC:
            begin
                next_result      = {flags.carry, operand[7:1]};
                next_flags.carry = operand[0];
            end
            OP_DIR:
            begin
                next_result = acc;
            end
            default:
            begin
                next_result = operand;
            end
        endcase
    end

    always_comb
    begin
        case (phase)
            PH_DECODE:  next_phase = PH_READ;
            PH_READ:    next_phase = PH_PROCESS;
            PH_PROCESS: next_phase = PH_WRITE;
            PH_WRITE:   next_phase = PH_DECODE;
            default:    next_phase = PH_DECODE;
        endcase
    end

    // file write only in the write phase with destination one
    assign fileWr = busy && phase == PH_WRITE && instr.dest && instr.op != OP_DIR;

    // instructions write only while busy and software only while idle, so the port is never contended
    wire logic       ramWrEn   = fileWr | fileWrSw;
    wire logic [6:0] ramWrAddr = busy ? instr.addr : paddr[8:2];
    wire logic [7:0] ramWrData = busy ? result : pwdata[7:0];

    file_ram u_ram
    (
        .clock  (clock),
        .wrEn   (ramWrEn),
        .wrAddr (ramWrAddr),
        .wrData (ramWrData),
        .rdAddr (instr.addr),
        .rdData (ramRd)
    );

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy  <= 1'b0;
            phase <= PH_DECODE;
            instr <= '{op: OP_SUB, dest: 1'b0, addr: 7'h00};
        end
        else if (startCmd)
        begin
            busy  <= 1'b1;
            phase <= PH_DECODE;
            instr <= '{op: op_e'(pwdata[`CTRL_OP_LSB +: 3]), dest: pwdata[`CTRL_DEST_BIT],
                       addr: pwdata[`CTRL_ADDR_LSB +: 7]};
        end
        else if (busy)
        begin
            phase <= next_phase;
            busy  <= phase != PH_WRITE;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            operand <= 8'h00;
            result  <= 8'h00;
            flags   <= `RST_FLAGS;
        end
        else if (busy && phase == PH_READ)
        begin
            operand <= ramRd;
        end
        else if (busy && phase == PH_PROCESS)
        begin
            result <= next_result;
            flags  <= next_flags;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc    <= `RST_ACC;
            dirReg <= `RST_DIRREG;
        end
        else if (accWrSw)
        begin
            acc <= pwdata[7:0];
        end
        else if (busy && phase == PH_WRITE)
        begin
            if (instr.op == OP_DIR)
            begin
                dirReg <= result;
            end
            else if (!instr.dest)
            begin
                acc <= result;
            end
        end
    end

    wire logic [31:0] rdMux = hitCtrl   ? {31'h0, busy} :
                              hitAcc    ? {24'h0, acc} :
                              hitStatus ? {28'h0, busy, flags.zero, flags.digitCarry, flags.carry} :
                              hitResult ? {24'h0, result} :
                              hitDir    ? {24'h0, dirReg} : 32'h0;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel & ~penable;
            prdata  <= rdMux;
            pslverr <= psel & ~penable & ~mapped;
        end
    end

    property p_phase_walk;
        @(posedge clock) disable iff (!rst_n)
        startCmd |=> phase == PH_DECODE ##1 phase == PH_READ ##1 phase == PH_PROCESS ##1 phase == PH_WRITE ##1 !busy;
    endproperty
    a_phase_walk: assert property (p_phase_walk) else $error("phase walk broken");

    property p_addr_range;
        @(posedge clock) disable iff (!rst_n)
        startCmd |=> instr.addr == $past(pwdata[6:0]) && instr.dest == $past(pwdata[7]);
    endproperty
    a_addr_range: assert property (p_addr_range) else $error("operand capture wrong");

    property p_sub_result;
        @(posedge clock) disable iff (!rst_n)
        busy && phase == PH_PROCESS && instr.op == OP_SUB |=> result == 8'($past(operand) - $past(acc));
    endproperty
    a_sub_result: assert property (p_sub_result) else $error("subtract result wrong");

    property p_borrow;
        @(posedge clock) disable iff (!rst_n)
        busy && phase == PH_PROCESS && instr.op == OP_SUB |=> flags.carry == ($past(operand) >= $past(acc));
    endproperty
    a_borrow: assert property (p_borrow) else $error("borrow carry wrong");

    property p_dest_acc;
        @(posedge clock) disable iff (!rst_n)
        busy && phase == PH_WRITE && !instr.dest && instr.op != OP_DIR && !accWrSw |=> acc == $past(result);
    endproperty
    a_dest_acc: assert property (p_dest_acc) else $error("accumulator not written");

    property p_rlc;
        @(posedge clock) disable iff (!rst_n)
        busy && phase == PH_PROCESS && instr.op == OP_RLC |=>
            result == {$past(operand[6:0]), $past(flags.carry)} && flags.carry == $past(operand[7]);
    endproperty
    a_rlc: assert property (p_rlc) else $error("rotate left wrong");

    property p_rrc;
        @(posedge clock) disable iff (!rst_n)
        busy && phase == PH_PROCESS && instr.op == OP_RRC |=>
            result == {$past(flags.carry), $past(operand[7:1])} && flags.carry == $past(operand[0]);
    endproperty
    a_rrc: assert property (p_rrc) else $error("rotate right wrong");

    property p_swap;
        @(posedge clock) disable iff (!rst_n)
        busy && phase == PH_PROCESS && instr.op == OP_SWAP |=>
            result == {$past(operand[3:0]), $past(operand[7:4])} && $stable(flags);
    endproperty
    a_swap: assert property (p_swap) else $error("nibble exchange wrong");

    c_sub:  cover property (@(posedge clock) busy && phase == PH_WRITE && instr.op == OP_SUB && !flags.carry);
    c_rlc:  cover property (@(posedge clock) busy && phase == PH_WRITE && instr.op == OP_RLC && instr.dest);
    c_swap: cover property (@(posedge clock) busy && phase == PH_WRITE && instr.op == OP_SWAP);
endmodule

// ==== dv/apb_host_model.sv ====
// Purpose: apb requester standing in for the core sequencer
// Assumes: one transfer at a time, zero or more wait states
// Notes: signals change only just after a rising edge
`timescale 1ns/1ps
module apb_host_model
(
    input  wire logic        clock,   // core clock
    output logic             psel,    // select
    output logic             penable, // access phase
    output logic             pwrite,  // direction
    output logic      [11:0] paddr,   // byte address
    output logic      [31:0] pwdata,  // write data
    input  wire logic        pready,  // ready
    input  wire logic [31:0] prdata,  // read data
    input  wire logic        pslverr  // error
);
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
    end

    // request is held until pready is seen high at a rising edge
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do
            @(posedge clock);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;
    endtask
endmodule

// ==== dv/byte_subtract_swap_rotate_exec_tb_top.sv ====
// Purpose: self-checking bench for the byte execution datapath
// Assumes: file memory starts unknown, so every byte an instruction result depends on is preloaded first
// Notes: results landing in the file memory in t_dest_file are read back by a later instruction into the accumulator
`timescale 1ns/1ps
`include "alu_exec_cfg.svh"
module byte_subtract_swap_rotate_exec_tb_top;
    import alu_exec_pkg::*;
    logic        clock;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    flags_s      flags;
    logic        busy;
    int          n_fail;
    int          checks_done;
    int          cycles;

    byte_subtract_swap_rotate_exec u_dut
    (
        .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .flags(flags), .busy(busy)
    );
    apb_host_model u_host
    (
        .clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr)
    );

    always #5 clock = ~clock;

    task automatic end_of_test();
        if (n_fail == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        e;
        u_host.xfer(1'b1, a, d, rd, e);
    endtask

    task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        e;
        u_host.xfer(1'b0, a, 32'h0, rd, e);
        chk(name, rd, exp);
    endtask

    task automatic go(input op_e op, input logic dest, input logic [6:0] addr);
        wr(`OFF_CTRL, {1'b1, 20'h0, op, dest, addr});
    endtask

    // preload one file byte through the write-only window
    task automatic ld(input logic [6:0] a, input logic [7:0] v);
        wr(`OFF_FILE + {3'h0, a, 2'b00}, {24'h0, v});
    endtask

    // busy must stand exactly for the four phases after the start edge
    task automatic wait_phases();
        int n;
        n = 0;
        repeat (6)
        begin
            #1;
            if (busy === 1'b1)
                n++;
            @(posedge clock);
        end
        chk("busy cycles", n, 4);
    endtask

    task automatic t_reset_values();
        rdchk("acc reset", `OFF_ACC, 32'h0);
        rdchk("dirreg reset", `OFF_DIRREG, 32'hff);
        rdchk("status reset", `OFF_STATUS, 32'h0);
        chk("flags reset", {29'h0, flags}, 32'h0);
    endtask

    task automatic t_unmapped();
        logic [31:0] rd;
        logic        e;
        u_host.xfer(1'b0, 12'h014, 32'h0, rd, e);
        chk("unmapped error", {31'h0, e}, 32'h1);
    endtask

    task automatic t_dir_load();
        wr(`OFF_ACC, 32'h5a);
        go(OP_DIR, 1'b0, 7'h00);
        wait_phases();
        rdchk("dirreg load", `OFF_DIRREG, 32'h5a);
    endtask

    // positive, zero and negative differences; flags are {zero, digit carry, carry}
    task automatic t_sub();
        logic [7:0] fv[3];
        logic [7:0] res[3];
        logic [2:0] fl[3];
        fv  = '{8'h03, 8'h02, 8'h01};
        res = '{8'h01, 8'h00, 8'hff};
        fl  = '{3'h3, 3'h7, 3'h0};
        for (int i = 0; i < 3; i++)
        begin
            ld(7'h10, fv[i]);
            wr(`OFF_ACC, 32'h02);
            go(OP_SUB, 1'b0, 7'h10);
            wait_phases();
            rdchk("sub result", `OFF_ACC, {24'h0, res[i]});
            rdchk("sub result reg", `OFF_RESULT, {24'h0, res[i]});
            chk("sub flags", {29'h0, flags}, {29'h0, fl[i]});
        end
    endtask

    // destination one at both boundary addresses, read back by destination-zero ops
    task automatic t_dest_file();
        ld(7'h7f, 8'ha5);
        ld(7'h00, 8'he6);
        wr(`OFF_ACC, 32'h5a);
        go(OP_RLC, 1'b1, 7'h00);
        wait_phases();
        rdchk("acc kept rlc", `OFF_ACC, 32'h5a);
        rdchk("rlc result", `OFF_RESULT, 32'hcc);
        chk("rlc carry", {29'h0, flags}, 32'h1);
        go(OP_SWAP, 1'b1, 7'h7f);
        wait_phases();
        rdchk("acc kept swap", `OFF_ACC, 32'h5a);
        chk("swap flags", {29'h0, flags}, 32'h1);
        go(OP_RRC, 1'b0, 7'h00);
        wait_phases();
        rdchk("rrc to acc", `OFF_ACC, 32'he6);
        chk("rrc carry", {29'h0, flags}, 32'h0);
        go(OP_SWAP, 1'b0, 7'h7f);
        wait_phases();
        rdchk("swap back", `OFF_ACC, 32'ha5);
        go(op_e'(3'h5), 1'b0, 7'h7f);
        wait_phases();
        rdchk("spare op", `OFF_ACC, 32'h5a);
    endtask

    task automatic t_busy_refuse();
        ld(7'h07, 8'h12);
        go(OP_SWAP, 1'b1, 7'h07);
        wr(`OFF_ACC, 32'h33);
        repeat (6) @(posedge clock);
        rdchk("acc while busy", `OFF_ACC, 32'h5a);
        go(OP_SWAP, 1'b1, 7'h07);
        rdchk("status busy", `OFF_STATUS, 32'h8);
        repeat (6) @(posedge clock);
    endtask

    task automatic t_reset_mid();
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rdchk("acc after reset", `OFF_ACC, 32'h0);
        chk("flags after reset", {29'h0, flags}, 32'h0);
    endtask

    initial
    begin
        clock = 1'b0;
        rst_n = 1'b0;
        n_fail = 0;
        checks_done = 0;
        cycles = 0;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        t_reset_values();
        t_unmapped();
        t_dir_load();
        t_sub();
        t_dest_file();
        t_busy_refuse();
        t_reset_mid();
        end_of_test();
    end
endmodule
